// [logic/add_and_bitclear_exec.sv]
// Execution unit for add-to-file, AND-literal, AND-with-file and bit-clear.
// Assumes combinational file register read and a registered write the
// cycle after an instruction; one clock domain; port pins arrive async.
//
// How it works
// - Pattern 0001 11df ffff adds the accumulator to the file register, stores the sum at the chosen destination, updates carry, half-carry and zero in one cycle.
// - Destination bit 0 sends a byte result to the accumulator and 1 writes it back to the file register.
// - Nibble 1110 ANDs the accumulator with the 8-bit literal into the accumulator and changes only zero.
// - Pattern 0001 01df ffff ANDs the accumulator with the file register to the chosen destination and changes only zero.
// - Nibble 0100 clears bit b of file register f and changes no flag.
// - The file address is instruction bits 4 to 0 (0 to 31) and the destination bit is 0 or 1.
// - A write to the free-running counter register clears its prescaler when the prescaler is assigned to it.
// - An I/O port register modified as a function of itself takes its operand from the pin levels.
//
// Decided for this implementation: the address map and the Avalon-MM slave port.
`timescale 1ns/1ns
module add_and_bitclear_exec
	import exec_pkg::*;
#(
	parameter logic [exec_pkg::FADDR_W-1:0] COUNTER_ADDR = exec_pkg::COUNTER_ADDR_DEF,
	parameter logic [exec_pkg::FADDR_W-1:0] PORT0_ADDR = exec_pkg::PORT0_ADDR_DEF
)
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// Instruction from fetch
	input wire logic instr_valid_i,
	input wire logic [exec_pkg::INSTR_W-1:0] instr_i,
	// File register read
	output logic [exec_pkg::FADDR_W-1:0] file_raddr_o,
	input wire logic [exec_pkg::DATA_W-1:0] file_rdata_i,
	// File register write
	output logic file_we_o,
	output logic [exec_pkg::FADDR_W-1:0] file_waddr_o,
	output logic [exec_pkg::DATA_W-1:0] file_wdata_o,
	// Counter prescaler
	input wire logic prescaler_to_counter_i,
	output logic prescaler_clr_o,
	// Port pin levels
	input wire logic [exec_pkg::DATA_W-1:0] port_pins_i [exec_pkg::NUM_PORTS],
	// Avalon-MM slave
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest
);
	import exec_pkg::*;

	logic rst_meta_reg, rst_sync_reg;
	logic [DATA_W-1:0] pin_meta_reg [NUM_PORTS];
	logic [DATA_W-1:0] pin_sync_reg [NUM_PORTS];
	logic [DATA_W-1:0] acc_reg, acc_next;
	logic [NUM_FLAGS-1:0] flags_reg, flags_next;
	logic enable_reg;
	logic [DATA_W-1:0] result_reg;
	logic rd_pend_reg;
	logic [31:0] rdata_reg;
	logic file_we_next, prescaler_clr_next;
	logic [DATA_W-1:0] result;

	// Operand fields
	logic [FADDR_W-1:0] faddr;
	logic dest;
	logic [BIDX_W-1:0] bidx;
	logic [DATA_W-1:0] lit;
	logic do_add, do_and_file, do_and_lit, do_clr_bit, to_file;
	logic [DATA_W-1:0] fop;
	logic [DATA_W:0] sum;
	// Nibble width for the half-carry sum
	localparam int HALF_W = DATA_W / 2;
	logic [HALF_W:0] low_sum;

	// Port index test, used for pin substitution
	function automatic logic is_port(input logic [FADDR_W-1:0] a);
		logic [FADDR_W-1:0] off;
		off = a - PORT0_ADDR;
		return (a >= PORT0_ADDR) && (off < FADDR_W'(NUM_PORTS));
	endfunction

	// Reset release through two flops
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end
		else
		begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end

	// Pin synchronisers; only the second stage is read
	genvar gp;
	generate
		for (gp = 0; gp < NUM_PORTS; gp++)
		begin : g_pin
			always_ff @(posedge clk_i or negedge rst_sync_reg)
			begin
				if (!rst_sync_reg)
				begin
					pin_meta_reg[gp] <= '0;
					pin_sync_reg[gp] <= '0;
				end
				else
				begin
					pin_meta_reg[gp] <= port_pins_i[gp];
					pin_sync_reg[gp] <= pin_meta_reg[gp];
				end
			end
		end
	endgenerate

	// Field extraction and decode
	always_comb
	begin
		faddr = instr_i[FADDR_LSB +: FADDR_W];
		dest = instr_i[DEST_BIT];
		bidx = instr_i[BIDX_LSB +: BIDX_W];
		lit = instr_i[LIT_LSB +: DATA_W];
		do_add = instr_valid_i && enable_reg
			&& (instr_i[OP6_LSB +: $bits(OP6_ADD_FILE)] == OP6_ADD_FILE);
		do_and_file = instr_valid_i && enable_reg
			&& (instr_i[OP6_LSB +: $bits(OP6_AND_FILE)] == OP6_AND_FILE);
		do_and_lit = instr_valid_i && enable_reg
			&& (instr_i[OP4_LSB +: $bits(OP4_AND_LIT)] == OP4_AND_LIT);
		do_clr_bit = instr_valid_i && enable_reg
			&& (instr_i[OP4_LSB +: $bits(OP4_CLR_BIT)] == OP4_CLR_BIT);
		to_file = do_clr_bit || ((do_add || do_and_file) && dest == DEST_FILE);
	end

	assign file_raddr_o = faddr;

	// Operand: pins stand in for a port that is rewritten in place
	always_comb
	begin
		fop = file_rdata_i;
		if (to_file && is_port(faddr))
			fop = pin_sync_reg[2'(faddr - PORT0_ADDR)];
	end

	// Arithmetic and logic result
	always_comb
	begin
		sum = {1'b0, acc_reg} + {1'b0, fop};
		low_sum = {1'b0, acc_reg[HALF_W-1:0]} + {1'b0, fop[HALF_W-1:0]};
		result = '0;
		if (do_add)
			result = sum[DATA_W-1:0];
		else if (do_and_file)
			result = acc_reg & fop;
		else if (do_and_lit)
			result = acc_reg & lit;
		else if (do_clr_bit)
			result = fop & ~(DATA_W'(1) << bidx);
	end

	// Next accumulator and flags; an instruction beats a bus write
	always_comb
	begin
		acc_next = acc_reg;
		flags_next = flags_reg;
		if (avs_write && !avs_waitrequest && avs_address == OFS_ACC)
			acc_next = avs_writedata[DATA_W-1:0];
		if (avs_write && !avs_waitrequest && avs_address == OFS_FLAGS)
			flags_next = avs_writedata[NUM_FLAGS-1:0];
		if ((do_add || do_and_file) && dest == DEST_ACC)
			acc_next = result;
		if (do_and_lit)
			acc_next = result;
		if (do_add)
		begin
			flags_next[FLAG_CARRY] = sum[DATA_W];
			flags_next[FLAG_HALF] = low_sum[HALF_W];
		end
		if (do_add || do_and_file || do_and_lit)
			flags_next[FLAG_ZERO] = (result == '0);
	end

	// Accumulator and flag state
	always_ff @(posedge clk_i or negedge rst_sync_reg)
	begin
		if (!rst_sync_reg)
		begin
			acc_reg <= ACC_RESET;
			flags_reg <= FLAGS_RESET;
		end
		else
		begin
			acc_reg <= acc_next;
			flags_reg <= flags_next;
		end
	end

	// File write and prescaler strobe, issued one cycle after decode
	always_comb
	begin
		file_we_next = to_file;
		prescaler_clr_next = to_file && faddr == COUNTER_ADDR && prescaler_to_counter_i;
	end

	always_ff @(posedge clk_i or negedge rst_sync_reg)
	begin
		if (!rst_sync_reg)
		begin
			file_we_o <= 1'b0;
			file_waddr_o <= '0;
			file_wdata_o <= '0;
			prescaler_clr_o <= 1'b0;
			result_reg <= '0;
		end
		else
		begin
			file_we_o <= file_we_next;
			file_waddr_o <= faddr;
			file_wdata_o <= result;
			prescaler_clr_o <= prescaler_clr_next;
			if (do_add || do_and_file || do_and_lit || do_clr_bit)
				result_reg <= result;
		end
	end

	// Control register
	always_ff @(posedge clk_i or negedge rst_sync_reg)
	begin
		if (!rst_sync_reg)
			enable_reg <= CTRL_ENABLE_RESET;
		else if (avs_write && avs_address == OFS_CTRL)
			enable_reg <= avs_writedata[CTRL_ENABLE];
	end

	// Writes never wait; reads take one wait state so data leave a flop
	assign avs_waitrequest = avs_read && !rd_pend_reg;
	assign avs_readdata = rdata_reg;

	always_ff @(posedge clk_i or negedge rst_sync_reg)
	begin
		if (!rst_sync_reg)
		begin
			rd_pend_reg <= 1'b0;
			rdata_reg <= '0;
		end
		else
		begin
			rd_pend_reg <= avs_read && !rd_pend_reg;
			if (avs_read && !rd_pend_reg)
			begin
				if (avs_address == OFS_ACC)
					rdata_reg <= 32'(acc_reg);
				else if (avs_address == OFS_FLAGS)
					rdata_reg <= 32'(flags_reg);
				else if (avs_address == OFS_CTRL)
					rdata_reg <= 32'(enable_reg);
				else if (avs_address == OFS_RESULT)
					rdata_reg <= 32'(result_reg);
				else
					rdata_reg <= '0;
			end
		end
	end
endmodule

// [logic/exec_pkg.sv]
// Shared constants for the add / AND / bit-clear execution block.
// Assumes a 12-bit instruction word and an 8-bit data path.
package exec_pkg;
	localparam int INSTR_W = 12;
	localparam int DATA_W = 8;
	localparam int FADDR_W = 5;
	localparam int BIDX_W = 3;

	// Instruction fields
	localparam int FADDR_LSB = 0;
	localparam int DEST_BIT = 5;
	localparam int BIDX_LSB = 5;
	localparam int LIT_LSB = 0;
	localparam int OP6_LSB = 6;
	localparam int OP4_LSB = 8;

	// Opcode patterns
	localparam logic [5:0] OP6_ADD_FILE = 6'h07; // 0001 11
	localparam logic [5:0] OP6_AND_FILE = 6'h05; // 0001 01
	localparam logic [3:0] OP4_AND_LIT = 4'he; // 1110
	localparam logic [3:0] OP4_CLR_BIT = 4'h4; // 0100

	// Destination select values
	localparam logic DEST_ACC = 1'b0;
	localparam logic DEST_FILE = 1'b1;

	// Bus register byte offsets
	localparam logic [3:0] OFS_ACC = 4'h0;
	localparam logic [3:0] OFS_FLAGS = 4'h4;
	localparam logic [3:0] OFS_CTRL = 4'h8;
	localparam logic [3:0] OFS_RESULT = 4'hc;

	// Flag positions in the flags register
	localparam int FLAG_CARRY = 0;
	localparam int FLAG_HALF = 1;
	localparam int FLAG_ZERO = 2;
	localparam int NUM_FLAGS = 3;
	localparam int CTRL_ENABLE = 0;

	// Reset values
	localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
	localparam logic [NUM_FLAGS-1:0] FLAGS_RESET = 3'h0;
	localparam logic CTRL_ENABLE_RESET = 1'b1;

	// File addresses of special registers
	localparam logic [FADDR_W-1:0] COUNTER_ADDR_DEF = 5'h01;
	localparam logic [FADDR_W-1:0] PORT0_ADDR_DEF = 5'h05;
	localparam int NUM_PORTS = 3;
endpackage

// [verification/exec_chk.sv]
// Port checker for the add / AND / bit-clear unit.
// Assumes file-writing instructions come only while the unit is enabled,
// and default special addresses.
`timescale 1ns/1ns
module exec_chk
	import exec_pkg::*;
(
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic instr_valid_i,
	input wire logic [exec_pkg::INSTR_W-1:0] instr_i,
	input wire logic [exec_pkg::FADDR_W-1:0] file_raddr_o,
	input wire logic [exec_pkg::DATA_W-1:0] file_rdata_i,
	input wire logic file_we_o,
	input wire logic [exec_pkg::FADDR_W-1:0] file_waddr_o,
	input wire logic [exec_pkg::DATA_W-1:0] file_wdata_o,
	input wire logic prescaler_to_counter_i,
	input wire logic prescaler_clr_o,
	input wire logic avs_read,
	input wire logic avs_waitrequest
);
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (!nrst_i);
	// Decode; port addresses excluded since pins replace the latch
	logic add_c, andf_c, lit_c, clr_c, port_f, wf;
	logic [7:0] mask;
	assign add_c = instr_valid_i && instr_i[11:6] == OP6_ADD_FILE;
	assign andf_c = instr_valid_i && instr_i[11:6] == OP6_AND_FILE;
	assign lit_c = instr_valid_i && instr_i[11:8] == OP4_AND_LIT;
	assign clr_c = instr_valid_i && instr_i[11:8] == OP4_CLR_BIT;
	assign port_f = file_raddr_o >= 5'h05 && file_raddr_o <= 5'h07;
	assign wf = (add_c || andf_c) && instr_i[DEST_BIT];
	assign mask = ~(8'h01 << instr_i[7:5]);
	property p_fwr;
		wf |=> file_we_o && file_waddr_o == $past(file_raddr_o);
	endproperty
	a_fwr: assert property (p_fwr) else $error("file write missing");
	property p_nowe;
		((add_c || andf_c) && !instr_i[DEST_BIT]) || lit_c |=> !file_we_o;
	endproperty
	a_nowe: assert property (p_nowe) else $error("stray file write");
	property p_clr;
		clr_c && !port_f |=> file_wdata_o == ($past(file_rdata_i) & $past(mask));
	endproperty
	a_clr: assert property (p_clr) else $error("bit clear data wrong");
	property p_andf;
		andf_c && instr_i[DEST_BIT] && !port_f |=> (file_wdata_o & ~$past(file_rdata_i)) == 8'h00;
	endproperty
	a_andf: assert property (p_andf) else $error("AND result too wide");
	property p_raddr;
		instr_valid_i |-> file_raddr_o == instr_i[4:0];
	endproperty
	a_raddr: assert property (p_raddr) else $error("read address wrong");
	property p_psc;
		(wf || clr_c) && file_raddr_o == COUNTER_ADDR_DEF && prescaler_to_counter_i
			|=> prescaler_clr_o;
	endproperty
	a_psc: assert property (p_psc) else $error("prescaler not cleared");
	property p_npsc;
		!prescaler_to_counter_i |=> !prescaler_clr_o;
	endproperty
	a_npsc: assert property (p_npsc) else $error("prescaler cleared");
	property p_rdw;
		$rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest;
	endproperty
	a_rdw: assert property (p_rdw) else $error("read wait state wrong");
	c_add: cover property (wf);
	c_clr: cover property (clr_c && port_f);
	c_psc: cover property (prescaler_clr_o);
endmodule
bind add_and_bitclear_exec exec_chk i_exec_chk (.*);

// [verification/tb_top.sv]
// Bench for the add / AND / bit-clear unit.
// Models the file memory itself; ports are driven directly.
`timescale 1ns/1ns
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin failures++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module tb_top;
	import exec_pkg::*;
	logic clk = 0, nrst = 0, iv = 0, pta = 0, rd = 0, wr = 0, we, pclr, wt, seen = 0;
	logic [11:0] ins = 0;
	logic [4:0] ra, wa;
	logic [7:0] fw;
	logic [7:0] mem [32];
	logic [7:0] pins [3] = '{8'h0f, 8'h00, 8'h00};
	logic [3:0] adr = 0;
	logic [31:0] wd = 0, rdat, q;
	int failures = 0, checks_done = 0;
	always #50 clk = ~clk;
	// File memory write and prescaler strobe capture
	always @(posedge clk)
	begin
		if (we)
			mem[wa] <= fw;
		if (pclr)
			seen <= 1;
	end
	add_and_bitclear_exec i_add_and_bitclear_exec (.clk_i(clk), .nrst_i(nrst),
		.instr_valid_i(iv), .instr_i(ins), .file_raddr_o(ra), .file_rdata_i(mem[ra]),
		.file_we_o(we), .file_waddr_o(wa), .file_wdata_o(fw), .prescaler_to_counter_i(pta),
		.prescaler_clr_o(pclr), .port_pins_i(pins), .avs_address(adr), .avs_read(rd),
		.avs_write(wr), .avs_writedata(wd), .avs_readdata(rdat), .avs_waitrequest(wt));
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		adr <= a;
		wd <= d;
		wr <= w;
		rd <= !w;
		// Hold the request until an edge sees waitrequest low; only the watchdog ends a hang
		do
			@(posedge clk);
		while (wt);
		q = rdat;
		wr <= 0;
		rd <= 0;
	endtask
	task automatic rc(input logic [3:0] a, input logic [31:0] e);
		bus(0, a, 0);
		`CHK(q, e)
	endtask
	task automatic ex(input logic [11:0] i);
		@(posedge clk);
		iv <= 1;
		ins <= i;
		@(posedge clk);
		iv <= 0;
		repeat (2) @(posedge clk);
	endtask
	task end_of_test;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial
	begin
		#2000000;
		failures++;
		end_of_test;
	end
	initial
	begin
		repeat (5) @(posedge clk);
		nrst <= 1;
		repeat (3) @(posedge clk);
		rc(OFS_ACC, 0);
		rc(OFS_FLAGS, 0);
		bus(1, 4'h2, 32'hff);
		rc(4'h2, 0);
		mem[3] <= 8'h78;
		bus(1, OFS_ACC, 32'h88);
		ex(12'h1e3);
		`CHK(mem[3], 8'h00)
		rc(OFS_FLAGS, 32'h7);
		rc(OFS_ACC, 32'h88);
		mem[4] <= 8'hc2;
		bus(1, OFS_ACC, 32'h17);
		ex(12'h1c4);
		rc(OFS_ACC, 32'hd9);
		rc(OFS_FLAGS, 0);
		`CHK(mem[4], 8'hc2)
		mem[8] <= 8'h01;
		bus(1, OFS_ACC, 32'h0f);
		ex(12'h1c8);
		rc(OFS_FLAGS, 32'h2);
		bus(1, OFS_FLAGS, 32'h3);
		bus(1, OFS_ACC, 32'ha3);
		ex(12'he5f);
		rc(OFS_ACC, 32'h03);
		rc(OFS_FLAGS, 32'h3);
		ex(12'he00);
		rc(OFS_FLAGS, 32'h7);
		mem[9] <= 8'hc2;
		bus(1, OFS_ACC, 32'h17);
		ex(12'h169);
		`CHK(mem[9], 8'h02)
		rc(OFS_FLAGS, 32'h3);
		ex(12'h149);
		rc(OFS_ACC, 32'h02);
		rc(OFS_RESULT, 32'h02);
		// A disabled unit must ignore an instruction completely
		rc(OFS_CTRL, 32'h1);
		bus(1, OFS_CTRL, 32'h0);
		ex(12'he00);
		rc(OFS_ACC, 32'h02);
		rc(OFS_FLAGS, 32'h3);
		bus(1, OFS_CTRL, 32'h1);
		rc(OFS_CTRL, 32'h1);
		mem[10] <= 8'hc7;
		ex(12'h4ea);
		`CHK(mem[10], 8'h47)
		rc(OFS_FLAGS, 32'h3);
		mem[5] <= 8'hff;
		ex(12'h405);
		`CHK(mem[5], 8'h0e)
		`CHK(seen, 1'b0)
		mem[1] <= 8'hff;
		pta <= 1;
		ex(12'h401);
		`CHK(seen, 1'b1)
		`CHK(mem[1], 8'hfe)
		end_of_test;
	end
endmodule
